// ===== design/flash_host_defs.svh
// Opcodes, field values and timing counts for the serial flash host.
// Assumes a 50 MHz system clock; included by bare name.
`ifndef FLASH_HOST_DEFS_SVH
`define FLASH_HOST_DEFS_SVH

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define OP_RD_FAST 8'h0B
`define OP_RD_SLOW 8'h03
`define OP_RD_DUAL 8'h3B
`define OP_PG_ERASE 8'h81
`define OP_BE_4K 8'h20
`define OP_BE_32K 8'h52
`define OP_BE_64K 8'hD8
`define OP_CE_A 8'h60
`define OP_CE_B 8'hC7
`define OP_PROG 8'h02
`define OP_SEQ_A 8'hAD
`define OP_SEQ_B 8'hAF
`define OP_PROG_DUAL 8'hA2
`define OP_WR_EN 8'h06
`define OP_WR_DIS 8'h04
`define OP_PROT 8'h36
`define OP_UNPROT 8'h39
`define OP_RD_PROT 8'h3C
`define OP_OTP_PROG 8'h9B
`define OP_OTP_RD 8'h77
`define OP_RD_STAT 8'h05
`define OP_STAT_IRQ 8'h25
`define OP_WR_STAT1 8'h01
`define OP_WR_STAT2 8'h31
`define OP_RESET 8'hF0
`define OP_RD_ID 8'h9F
`define OP_DPD 8'hB9
`define OP_DPD_EXIT 8'hAB
`define OP_UDPD 8'h79

// ----------------------------------------
// Field values and limits
// ----------------------------------------
`define RESET_CONFIRM 8'hD0
`define ADDR_BITS 18
`define PAGE_BYTES 256
`define ID_BYTES_MAX 4

// ----------------------------------------
// Timing
// ----------------------------------------
`define SYS_MHZ 50
`define RDLF_MHZ 25
`define RDDO_MHZ 40
`define RDLF_HALF_MIN ((`SYS_MHZ + 2 * `RDLF_MHZ - 1) / (2 * `RDLF_MHZ))
`define RDDO_HALF_MIN ((`SYS_MHZ + 2 * `RDDO_MHZ - 1) / (2 * `RDDO_MHZ))
`define SYNC_LAT 2
`define SCK_HALF_DEF (`SYNC_LAT + 2)

`endif

// ===== design/flash_host_pkg.sv
// Types shared by the serial flash host files.
// Assumes nothing of its surroundings.
package flash_host_pkg;

  typedef enum logic [3:0] {
    S_IDLE, S_SETUP, S_OP, S_ADDR, S_DUMMY, S_WR, S_RD, S_HOLD, S_GAP
  } st_t;

  typedef struct packed {
    logic known;
    logic addr;
    logic [1:0] ndmy;
    logic rd;
    logic wr;
    logic dual;
    logic one;
    logic id;
  } cmd_info_t;

endpackage : flash_host_pkg

// ===== design/spi_sck_div.sv
// Serial clock divider for mode 0 with bit phase strobes.
// Assumes HALF >= SYNC_LAT + 2 so the sample strobe precedes the last.
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_defs.svh"

module spi_sck_div #(
  parameter int HALF = `SCK_HALF_DEF
) (
  input wire logic i_sys_clk, // System clock
  input wire logic i_rst_b, // Async reset, active low
  input wire logic i_run, // Run the clock
  output logic o_sck, // Serial clock, idles low
  output logic o_at0, // Phase counter at zero
  output logic o_lead, // Falling phase: drive next bit
  output logic o_samp, // Synced rising-edge sample point
  output logic o_last // Final cycle of a clock period
);

  localparam int PW = $clog2(2 * HALF);
  localparam logic [PW-1:0] P_LAST = PW'(2 * HALF - 1);
  localparam logic [PW-1:0] P_RISE = PW'(HALF - 1);
  localparam logic [PW-1:0] P_SAMP = PW'(HALF + `SYNC_LAT);

  logic [PW-1:0] ph_q;
  logic [PW-1:0] ph_d;
  logic sck_d;

  assign ph_d = !i_run ? '0 : (ph_q == P_LAST) ? '0 : ph_q + 1'b1;
  assign sck_d = i_run && (ph_q >= P_RISE) && (ph_q != P_LAST);
  assign o_at0 = (ph_q == '0);
  assign o_lead = i_run && o_at0;
  assign o_samp = i_run && (ph_q == P_SAMP);
  assign o_last = i_run && (ph_q == P_LAST);

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ph_q <= '0;
      o_sck <= 1'b0;
    end else begin
      ph_q <= ph_d;
      o_sck <= sck_d;
    end
  end

endmodule : spi_sck_div
`default_nettype wire

// ===== design/spi_flash_host.sv
// Host controller that issues commands to a serial NOR flash.
// Assumes the user side is on i_sys_clk and the flash runs SPI mode 0.
//
// Contract
// - Chip select first, opcode, bytes MSB first
// - 0Bh has one dummy; 03h clock limited
// - 3Bh dual read: address, one dummy
// - Page erase addressed; chip erase opcode only
// - Block erases 20h 52h D8h take address
// - 02h program: address, 1 to 256 bytes
// - Sequential program sends address once only
// - A2h dual program: address, 1-256 bytes
// - Write enable/disable are opcode only
// - Protect/unprotect addressed; 3Ch returns data
// - 9Bh programs OTP; 77h two dummies
// - 05h reads status; 01h/31h one byte
// - 25h sends one dummy byte only
// - F0h reset confirmed by byte D0h
// - 9Fh returns one to four bytes
// - Power-down commands are opcode only
// - Mode 0: sample rising, change falling
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_defs.svh"

module spi_flash_host #(
  parameter int SCK_HALF = `SCK_HALF_DEF,
  parameter int LEN_W = 9
) (
  input wire logic i_sys_clk, // System clock
  input wire logic i_rst_b, // Async reset, active low
  input wire logic i_cmd_valid, // Command request
  input wire logic [7:0] i_cmd_op, // Command opcode
  input wire logic [23:0] i_cmd_addr, // Command address
  input wire logic [LEN_W-1:0] i_cmd_len, // Data byte count
  output logic o_cmd_ready, // Ready for a command
  output logic o_cmd_err, // Unknown opcode refused
  output logic o_done, // Command finished
  input wire logic i_wr_valid, // Write byte present
  input wire logic [7:0] i_wr_data, // Write byte
  output logic o_wr_take, // Write byte consumed
  output logic o_rd_valid, // Read byte present
  output logic [7:0] o_rd_data, // Read byte
  output logic o_cs_b, // Chip select, active low
  output logic o_sck, // Serial clock
  output logic o_si, // SI pin output
  output logic o_si_oe_b, // SI drive enable, active low
  input wire logic i_si, // SI pin input
  output logic o_so, // SO pin output
  output logic o_so_oe_b, // SO drive enable, active low
  input wire logic i_so // SO pin input
);

  localparam int WT_W = $clog2(SCK_HALF) + 1;
  localparam logic [WT_W-1:0] WT_END = WT_W'(SCK_HALF - 1);
  localparam logic [LEN_W-1:0] LEN_ONE = LEN_W'(1);
  localparam logic [LEN_W-1:0] LEN_PAGE = LEN_W'(`PAGE_BYTES);
  localparam logic [LEN_W-1:0] LEN_ID = LEN_W'(`ID_BYTES_MAX);

  // ----------------------------------------
  // Opcode decode
  // ----------------------------------------
  function automatic flash_host_pkg::cmd_info_t dec(input logic [7:0] op);
    flash_host_pkg::cmd_info_t c;
    c = '0;
    case (op)
      `OP_RD_FAST: begin
        c = '{1'b1, 1'b1, 2'd1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
      end
      `OP_RD_SLOW, `OP_RD_PROT: begin
        c = '{1'b1, 1'b1, 2'd0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
      end
      `OP_RD_DUAL: begin
        c = '{1'b1, 1'b1, 2'd1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
      end
      `OP_PG_ERASE, `OP_BE_4K, `OP_BE_32K, `OP_BE_64K,
      `OP_PROT, `OP_UNPROT: begin
        c = '{1'b1, 1'b1, 2'd0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
      end
      `OP_CE_A, `OP_CE_B, `OP_WR_EN, `OP_WR_DIS,
      `OP_DPD, `OP_DPD_EXIT, `OP_UDPD: begin
        c = '{1'b1, 1'b0, 2'd0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
      end
      `OP_PROG, `OP_OTP_PROG: begin
        c = '{1'b1, 1'b1, 2'd0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
      end
      `OP_SEQ_A, `OP_SEQ_B: begin
        c = '{1'b1, 1'b1, 2'd0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
      end
      `OP_PROG_DUAL: begin
        c = '{1'b1, 1'b1, 2'd0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
      end
      `OP_OTP_RD: begin
        c = '{1'b1, 1'b1, 2'd2, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
      end
      `OP_RD_STAT: begin
        c = '{1'b1, 1'b0, 2'd0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
      end
      `OP_STAT_IRQ: begin
        c = '{1'b1, 1'b0, 2'd1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
      end
      `OP_WR_STAT1, `OP_WR_STAT2, `OP_RESET: begin
        c = '{1'b1, 1'b0, 2'd0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
      end
      `OP_RD_ID: begin
        c = '{1'b1, 1'b0, 2'd0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
      end
      default: begin
        c = '0;
      end
    endcase
    return c;
  endfunction : dec

  // ----------------------------------------
  // State and wires
  // ----------------------------------------
  flash_host_pkg::st_t st_q;
  flash_host_pkg::st_t st_d;
  flash_host_pkg::st_t aft_op;
  flash_host_pkg::st_t aft_addr;
  flash_host_pkg::st_t aft_dmy;
  flash_host_pkg::cmd_info_t info;
  flash_host_pkg::cmd_info_t ainfo;
  logic [7:0] op_q;
  logic [`ADDR_BITS-1:0] addr_q;
  logic [LEN_W-1:0] rem_q;
  logic [LEN_W-1:0] rem_d;
  logic [LEN_W-1:0] len_a;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic [2:0] bc_q;
  logic [2:0] bc_n;
  logic [7:0] sh_q;
  logic [7:0] rx_q;
  logic [7:0] b_cur;
  logic [7:0] ld_byte;
  logic [7:0] addr_byte;
  logic [1:0] s1_q;
  logic [1:0] s2_q;
  logic [WT_W-1:0] wt_q;
  logic [WT_W-1:0] wt_d;
  logic seq_q;
  logic skip_q;
  logic lead;
  logic samp;
  logic last;
  logic at0;
  logic run;
  logic shifting;
  logic dual_ph;
  logic byte_end;
  logic stall;
  logic wr_avail;
  logic wt_done;
  logic accept;
  logic si_rel;

  assign info = dec(op_q);
  assign ainfo = dec(i_cmd_op);
  assign accept = (st_q == flash_host_pkg::S_IDLE) && i_cmd_valid;
  assign wt_done = (wt_q == WT_END);
  assign shifting = (st_q inside {flash_host_pkg::S_OP,
      flash_host_pkg::S_ADDR, flash_host_pkg::S_DUMMY,
      flash_host_pkg::S_WR, flash_host_pkg::S_RD});
  assign dual_ph = info.dual && (st_q inside {flash_host_pkg::S_WR,
      flash_host_pkg::S_RD});
  assign bc_n = bc_q + (dual_ph ? 3'h2 : 3'h1);
  assign byte_end = last && (bc_n == 3'h0);
  assign wr_avail = i_wr_valid || (op_q == `OP_RESET);
  assign stall = (st_q == flash_host_pkg::S_WR) && (bc_q == 3'h0) &&
      at0 && !wr_avail;
  assign run = shifting && !stall;

  assign aft_dmy = info.wr ? flash_host_pkg::S_WR :
      info.rd ? flash_host_pkg::S_RD : flash_host_pkg::S_HOLD;
  assign aft_addr = (info.ndmy != 2'd0) ? flash_host_pkg::S_DUMMY : aft_dmy;
  assign aft_op = (info.addr && !skip_q) ? flash_host_pkg::S_ADDR : aft_addr;

  assign len_a = ainfo.one ? LEN_ONE :
      (i_cmd_len == '0) ? LEN_ONE :
      (ainfo.wr && i_cmd_len > LEN_PAGE) ? LEN_PAGE :
      (ainfo.id && i_cmd_len > LEN_ID) ? LEN_ID : i_cmd_len;

  assign addr_byte = (cnt_q == 2'd2) ? {6'h00, addr_q[17:16]} :
      (cnt_q == 2'd1) ? addr_q[15:8] : addr_q[7:0];
  assign ld_byte = (st_q == flash_host_pkg::S_OP) ? op_q :
      (st_q == flash_host_pkg::S_ADDR) ? addr_byte :
      (st_q != flash_host_pkg::S_WR) ? 8'h00 :
      (op_q == `OP_RESET) ? `RESET_CONFIRM : i_wr_data;
  assign b_cur = (bc_q == 3'h0) ? ld_byte : sh_q;
  // Let go of SI before the device drives it
  assign si_rel = info.dual && info.rd && ((st_d inside {
      flash_host_pkg::S_RD, flash_host_pkg::S_HOLD}) ||
      (st_q == flash_host_pkg::S_DUMMY && cnt_q == 2'd0 &&
      bc_q == 3'h7 && samp));

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    case (st_q)
      flash_host_pkg::S_IDLE: begin
        if (accept && ainfo.known) st_d = flash_host_pkg::S_SETUP;
      end
      flash_host_pkg::S_SETUP: begin
        if (wt_done) st_d = flash_host_pkg::S_OP;
      end
      flash_host_pkg::S_OP: begin
        if (byte_end) st_d = aft_op;
      end
      flash_host_pkg::S_ADDR: begin
        if (byte_end && cnt_q == 2'd0) st_d = aft_addr;
      end
      flash_host_pkg::S_DUMMY: begin
        if (byte_end && cnt_q == 2'd0) st_d = aft_dmy;
      end
      flash_host_pkg::S_WR, flash_host_pkg::S_RD: begin
        if (byte_end && rem_q == LEN_ONE) st_d = flash_host_pkg::S_HOLD;
      end
      flash_host_pkg::S_HOLD: begin
        if (wt_done) st_d = flash_host_pkg::S_GAP;
      end
      flash_host_pkg::S_GAP: begin
        if (wt_done) st_d = flash_host_pkg::S_IDLE;
      end
      default: begin
        st_d = flash_host_pkg::S_IDLE;
      end
    endcase
  end

  assign wt_d = (st_d != st_q) ? '0 : wt_q + 1'b1;
  assign cnt_d = (st_d == flash_host_pkg::S_ADDR &&
      st_q != flash_host_pkg::S_ADDR) ? 2'd2 :
      (st_d == flash_host_pkg::S_DUMMY &&
      st_q != flash_host_pkg::S_DUMMY) ? info.ndmy - 2'd1 :
      byte_end ? cnt_q - 2'd1 : cnt_q;
  assign rem_d = accept ? len_a : (byte_end &&
      (st_q inside {flash_host_pkg::S_WR, flash_host_pkg::S_RD})) ?
      rem_q - LEN_ONE : rem_q;

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q <= flash_host_pkg::S_IDLE;
      wt_q <= '0;
      cnt_q <= 2'd0;
      rem_q <= '0;
    end else begin
      st_q <= st_d;
      wt_q <= wt_d;
      cnt_q <= cnt_d;
      rem_q <= rem_d;
    end
  end

  // Command capture; sequential mode stays until a known opcode other than ADh/AFh
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      op_q <= 8'h00;
      addr_q <= '0;
      seq_q <= 1'b0;
      skip_q <= 1'b0;
    end else if (accept && ainfo.known) begin
      op_q <= i_cmd_op;
      addr_q <= i_cmd_addr[`ADDR_BITS-1:0];
      seq_q <= ainfo.one && ainfo.addr;
      skip_q <= seq_q && ainfo.one && ainfo.addr;
    end
  end

  // ----------------------------------------
  // Bit engine
  // ----------------------------------------
  spi_sck_div #(
    .HALF(SCK_HALF)
  ) u_div (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_run(run),
    .o_sck(o_sck),
    .o_at0(at0),
    .o_lead(lead),
    .o_samp(samp),
    .o_last(last)
  );

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sh_q <= 8'h00;
      o_si <= 1'b0;
      o_so <= 1'b0;
    end else if (lead) begin
      sh_q <= dual_ph ? {b_cur[5:0], 2'b00} : {b_cur[6:0], 1'b0};
      // Dual data: bit 7 on SO
      o_si <= dual_ph ? b_cur[6] : b_cur[7];
      o_so <= b_cur[7];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bc_q <= 3'h0;
    end else if (!shifting) begin
      bc_q <= 3'h0;
    end else if (last) begin
      bc_q <= bc_n;
    end
  end

  // Pin inputs: bit 1 is SO, bit 0 is SI
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s1_q <= 2'b00;
      s2_q <= 2'b00;
    end else begin
      s1_q <= {i_so, i_si};
      s2_q <= s1_q;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_q <= 8'h00;
    end else if (samp) begin
      rx_q <= dual_ph ? {rx_q[5:0], s2_q} : {rx_q[6:0], s2_q[1]};
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cs_b <= 1'b1;
      o_si_oe_b <= 1'b0;
      o_so_oe_b <= 1'b1;
      o_cmd_ready <= 1'b0;
    end else begin
      o_cs_b <= (st_d inside {flash_host_pkg::S_IDLE, flash_host_pkg::S_GAP});
      o_si_oe_b <= si_rel;
      o_so_oe_b <= !((st_d == flash_host_pkg::S_WR) && info.dual);
      o_cmd_ready <= (st_d == flash_host_pkg::S_IDLE);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cmd_err <= 1'b0;
      o_done <= 1'b0;
      o_wr_take <= 1'b0;
      o_rd_valid <= 1'b0;
      o_rd_data <= 8'h00;
    end else begin
      o_cmd_err <= accept && !ainfo.known;
      o_done <= (st_q == flash_host_pkg::S_GAP) && wt_done;
      o_wr_take <= lead && (st_q == flash_host_pkg::S_WR) &&
          (bc_q == 3'h0) && (op_q != `OP_RESET);
      o_rd_valid <= byte_end && (st_q == flash_host_pkg::S_RD);
      if (byte_end && st_q == flash_host_pkg::S_RD) o_rd_data <= rx_q;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_cs_first;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    $rose(o_sck) |-> !o_cs_b && $past(!o_cs_b, 2);
  endproperty
  a_cs_first: assert property (p_cs_first)
    else $error("clock rose without chip select");

  property p_opcode_msb;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    $rose(o_sck) && st_q == flash_host_pkg::S_OP && bc_q == 3'h0
      |-> o_si == op_q[7];
  endproperty
  a_opcode_msb: assert property (p_opcode_msb)
    else $error("opcode MSB not first");

  property p_addr_top_zero;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    $rose(o_sck) && st_q == flash_host_pkg::S_ADDR && cnt_q == 2'd2 &&
      bc_q < 3'h6 |-> !o_si;
  endproperty
  a_addr_top_zero: assert property (p_addr_top_zero)
    else $error("upper address bit sent as one");

  property p_sck_high;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    $rose(o_sck) |-> o_sck [*3];
  endproperty
  a_sck_high: assert property (p_sck_high)
    else $error("serial clock high too short");

  property p_half_ok;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    $fell(o_sck) |-> !o_sck [*3];
  endproperty
  a_half_ok: assert property (p_half_ok)
    else $error("serial clock low too short");

  property p_dual_release;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    st_q == flash_host_pkg::S_RD && op_q == `OP_RD_DUAL |-> o_si_oe_b;
  endproperty
  a_dual_release: assert property (p_dual_release)
    else $error("SI driven during dual read");

  property p_whole_bytes;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    $rose(o_cs_b) |-> $past(bc_q) == 3'h0 && !o_sck;
  endproperty
  a_whole_bytes: assert property (p_whole_bytes)
    else $error("deselect inside a byte");

  property p_seq_one;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    st_q == flash_host_pkg::S_WR && info.one |-> rem_q == LEN_ONE;
  endproperty
  a_seq_one: assert property (p_seq_one)
    else $error("single-byte command sends more data");

  property p_bare_opcode;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    st_q == flash_host_pkg::S_ADDR && $past(st_q) == flash_host_pkg::S_OP
      |-> info.addr && !skip_q;
  endproperty
  a_bare_opcode: assert property (p_bare_opcode)
    else $error("address sent for opcode-only command");

  property p_reset_internal;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    st_q == flash_host_pkg::S_WR && op_q == `OP_RESET |-> !o_wr_take;
  endproperty
  a_reset_internal: assert property (p_reset_internal)
    else $error("reset confirm taken from user");

  property p_change_low;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    $changed(o_si) && !o_cs_b |-> !o_sck;
  endproperty
  a_change_low: assert property (p_change_low)
    else $error("SI changed while clock high");

endmodule : spi_flash_host
`default_nettype wire

// ===== tb/flash_dev_model.sv
// Behavioural serial flash device facing the host on resolved pin levels.
// Assumes mode 0 framing; array content is a fixed address pattern.
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model (
  input wire logic i_cs_b, // Chip select, active low
  input wire logic i_sck, // Serial clock
  input wire logic i_si, // SI wire level
  input wire logic i_so, // SO wire level
  output logic o_so, // SO drive value
  output logic o_si // SI drive value
);
  // ----------------------------------------
  // Frame capture and read stream
  // ----------------------------------------
  logic [7:0] frame [0:15];
  logic [7:0] op, sr, h, b;
  logic [17:0] a;
  logic seq_q = 1'b0, dead = 1'b0, rd = 1'b0;
  logic so_v = 1'b0, si_v = 1'b0;
  int n, nb, bsh, na, nd, k, nfr;
  int hdr = 8;

  function automatic logic [7:0] dat(input logic [17:0] x);
    return x[7:0] ^ {x[17:16], 6'h2A};
  endfunction : dat

  assign o_so = so_v;
  assign o_si = si_v;

  always @(negedge i_cs_b) begin
    n = 0;
    nb = 0;
    bsh = 0;
    hdr = 8;
    rd = 1'b0;
    dead = 1'b0;
    nfr++;
  end

  always @(posedge i_cs_b) begin
    so_v = ~so_v;
    si_v = ~si_v;
    if (nb > 0) seq_q = (op == 8'hAD || op == 8'hAF);
  end

  always @(posedge i_sck) begin
    if (!i_cs_b && !dead) begin
      if (!(rd && n >= hdr)) begin
        if (op == 8'hA2 && n >= hdr) begin
          sr = {sr[5:0], i_so, i_si};
          bsh += 2;
        end else begin
          sr = {sr[6:0], i_si};
          bsh += 1;
        end
        if (bsh == 8) begin
          bsh = 0;
          if (nb < 16) frame[nb] = sr;
          nb++;
        end
      end
      n++;
      if (n == 8) begin
        op = frame[0];
        // Packed as {known, read, dummy bytes, address bytes}
        case (op)
          8'h0B, 8'h3B: h = 8'hD3;
          8'h03, 8'h3C: h = 8'hC3;
          8'h77: h = 8'hE3;
          8'h05, 8'h9F: h = 8'hC0;
          8'h81, 8'h20, 8'h52, 8'hD8, 8'h02, 8'hA2: h = 8'h83;
          8'h36, 8'h39, 8'h9B: h = 8'h83;
          8'hAD, 8'hAF: h = seq_q ? 8'h80 : 8'h83;
          8'h25: h = 8'h90;
          8'h06, 8'h04, 8'h60, 8'hC7, 8'h01, 8'h31: h = 8'h80;
          8'hF0, 8'hB9, 8'hAB, 8'h79: h = 8'h80;
          default: h = 8'h00;
        endcase
        dead = !h[7];
        rd = h[6];
        nd = int'(h[5:4]);
        na = int'(h[3:0]);
        hdr = 8 * (1 + na + nd);
      end
    end
  end

  always @(negedge i_sck) begin
    if (!i_cs_b && rd && n >= hdr) begin
      k = n - hdr;
      a = (na == 3) ? {frame[1][1:0], frame[2], frame[3]} : 18'h0_0000;
      b = dat(a + 18'((op == 8'h3B) ? k / 4 : k / 8));
      if (op == 8'h3B) begin
        so_v = b[7 - 2 * (k % 4)];
        si_v = b[6 - 2 * (k % 4)];
      end else begin
        so_v = b[7 - k % 8];
      end
    end
  end
endmodule : flash_dev_model
`default_nettype wire

// ===== tb/spi_flash_command_front_end_test.sv
// Self-checking bench: flash host against the behavioural device model.
// Assumes design/ sources and tb/flash_dev_model.sv are compiled first.
`timescale 1ns/1ps
`default_nettype none
module spi_flash_command_front_end_test;
  // ----------------------------------------
  // Stimulus, pins and collectors
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst_b = 1'b0, cmd_valid = 1'b0, wr_en = 1'b1;
  logic [7:0] cmd_op = 8'h00;
  logic [23:0] cmd_addr = 24'h00_0000;
  logic [8:0] cmd_len = 9'h001;
  logic cmd_ready, cmd_err, done, wr_take, rd_valid, cs_b, sck;
  logic h_si, si_oe_b, h_so, so_oe_b, d_si, d_so, si_w, so_w;
  logic [7:0] rd_data;
  logic [7:0] wbuf [0:3] = '{8'hA5, 8'h3C, 8'h0F, 8'hC3};
  logic [7:0] oo [0:6] = '{8'h06, 8'h04, 8'h60, 8'hC7, 8'hB9, 8'hAB, 8'h79};
  logic [7:0] ao [0:5] = '{8'h81, 8'h20, 8'h52, 8'hD8, 8'h36, 8'h39};
  logic [7:0] rbuf [0:7];
  int widx = 0, rcnt = 0, cyc = 0, num_errors = 0, comparisons = 0;

  always #10 clk = ~clk;
  assign si_w = (si_oe_b === 1'b0) ? h_si : d_si;
  assign so_w = (so_oe_b === 1'b0) ? h_so : d_so;

  spi_flash_host #(.SCK_HALF(4), .LEN_W(9)) dut (
    .i_sys_clk(clk), .i_rst_b(rst_b), .i_cmd_valid(cmd_valid),
    .i_cmd_op(cmd_op), .i_cmd_addr(cmd_addr), .i_cmd_len(cmd_len),
    .o_cmd_ready(cmd_ready), .o_cmd_err(cmd_err), .o_done(done),
    .i_wr_valid(wr_en), .i_wr_data(wbuf[widx[1:0]]), .o_wr_take(wr_take),
    .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_cs_b(cs_b), .o_sck(sck),
    .o_si(h_si), .o_si_oe_b(si_oe_b), .i_si(si_w), .o_so(h_so),
    .o_so_oe_b(so_oe_b), .i_so(so_w)
  );
  flash_dev_model dev (
    .i_cs_b(cs_b), .i_sck(sck), .i_si(si_w), .i_so(so_w),
    .o_so(d_so), .o_si(d_si)
  );

  always @(negedge clk) if (wr_take === 1'b1) widx <= widx + 1;
  always @(negedge clk) begin
    if (rd_valid === 1'b1) begin
      rbuf[rcnt[2:0]] = rd_data;
      rcnt++;
    end
  end
  // Ceiling about five times the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      summarize();
    end
  end

  function automatic logic [7:0] dat(input logic [17:0] x);
    return x[7:0] ^ {x[17:16], 6'h2A};
  endfunction : dat

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask : chk1

  task automatic summarize;
    if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize

  // One command; frame bytes, write takes and read bytes are judged
  task automatic run(input logic [7:0] op, input logic [23:0] ad,
                     input int len, na, nd, nw, nr);
    logic [7:0] e [0:15];
    logic [7:0] fill;
    int f0, t;
    f0 = dev.nfr;
    rcnt = 0;
    widx = 0;
    e[0] = op;
    e[1] = {6'h00, ad[17:16]};
    e[2] = ad[15:8];
    e[3] = ad[7:0];
    for (int i = 0; i < nd + nw; i++) begin
      fill = (op == 8'hF0) ? 8'hD0 : wbuf[(i - nd) % 4];
      e[1 + na + i] = (i < nd) ? 8'h00 : fill;
    end
    @(negedge clk);
    for (t = 0; t < 50 && cmd_ready !== 1'b1; t++) @(negedge clk);
    chk1(cmd_ready, 1'b1);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = ad;
    cmd_len = 9'(len);
    @(negedge clk);
    cmd_valid = 1'b0;
    for (t = 0; t < 9000 && done !== 1'b1; t++) @(negedge clk);
    chk1(done, 1'b1);
    chk8(8'(dev.nfr - f0), 8'h01);
    chk8(8'(dev.nb), 8'(1 + na + nd + nw));
    for (int i = 0; i < 1 + na + nd + nw; i++) chk8(dev.frame[i], e[i]);
    chk8(8'(widx), 8'((op == 8'hF0) ? 0 : nw));
    chk8(8'(rcnt), 8'(nr));
    for (int i = 0; i < nr; i++) begin
      chk8(rbuf[i], dat((na == 3 ? ad[17:0] : 18'h0_0000) + 18'(i)));
    end
  endtask : run

  task automatic s_stall;
    @(negedge clk);
    wr_en = 1'b0;
    fork
      run(8'h02, 24'h12_34FE, 3, 3, 0, 3, 0);
      begin
        repeat (300) @(negedge clk);
        chk1(sck, 1'b0);
        chk1(cs_b, 1'b0);
        wr_en = 1'b1;
      end
    join
  endtask : s_stall

  task automatic s_unknown;
    int f0;
    f0 = dev.nfr;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_op = 8'h5E;
    @(posedge clk);
    @(negedge clk);
    cmd_valid = 1'b0;
    chk1(cmd_err, 1'b1);
    repeat (20) @(negedge clk);
    chk1(cs_b, 1'b1);
    chk1(cmd_ready, 1'b1);
    chk8(8'(dev.nfr - f0), 8'h00);
  endtask : s_unknown

  initial begin
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    foreach (oo[i]) run(oo[i], 24'h00_0000, 1, 0, 0, 0, 0);
    foreach (ao[i]) run(ao[i], 24'hFF_ABCD, 1, 3, 0, 0, 0);
    run(8'h0B, 24'h03_FFFE, 4, 3, 1, 0, 4);
    run(8'h03, 24'hC3_FFFF, 2, 3, 0, 0, 2);
    run(8'h3B, 24'h03_FFFD, 4, 3, 1, 0, 4);
    run(8'h3C, 24'h00_0100, 1, 3, 0, 0, 1);
    run(8'h77, 24'h00_0040, 2, 3, 2, 0, 2);
    run(8'h05, 24'h00_0000, 2, 0, 0, 0, 2);
    run(8'h9F, 24'h00_0000, 6, 0, 0, 0, 4);
    s_stall();
    run(8'hA2, 24'h00_0010, 2, 3, 0, 2, 0);
    run(8'h9B, 24'h00_0020, 2, 3, 0, 2, 0);
    run(8'h01, 24'h00_0000, 5, 0, 0, 1, 0);
    run(8'h31, 24'h00_0000, 1, 0, 0, 1, 0);
    run(8'hF0, 24'h00_0000, 1, 0, 0, 1, 0);
    run(8'h25, 24'h00_0000, 1, 0, 1, 0, 0);
    run(8'hAD, 24'h00_0200, 1, 3, 0, 1, 0);
    run(8'hAF, 24'h00_0200, 1, 0, 0, 1, 0);
    run(8'h06, 24'h00_0000, 1, 0, 0, 0, 0);
    run(8'hAD, 24'h00_0300, 1, 3, 0, 1, 0);
    s_unknown();
    summarize();
  end
endmodule : spi_flash_command_front_end_test
`default_nettype wire
